// file: core/lpddr_command_burst_interface.sv
// LPDDR device side: command decode, bank state, DDR bursts, refresh
// Assumes all pins asynchronous to clk_sys_in; link clock far slower
`timescale 1ns/1ps
`default_nettype none
module lpddr_command_burst_interface (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic ck_in,
  input wire logic ck_n_in,
  input wire logic cke_in,
  input wire logic cs_n_in,
  input wire logic ras_n_in,
  input wire logic cas_n_in,
  input wire logic we_n_in,
  input wire logic [1:0] ba_in,
  input wire logic [12:0] addr_in,
  input wire logic [1:0] dm_in,
  input wire logic [1:0] dqs_in,
  output logic [1:0] dqs_out,
  output logic [1:0] dqs_oe_n_out,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic dq_oe_n_out,
  input wire logic temp_hot_in,
  output logic [1:0] power_state_out,
  output logic [12:0] refresh_row_out,
  output logic protocol_error_out,
  output logic [3:0] last_cmd_out
);
  lpddr_pkg::state_t st_ff;
  lpddr_pkg::state_t nxt_st;
  logic [31:0] mem [256];
  lpddr_pkg::pins_t raw;
  lpddr_pkg::wr_item_t pop_item;
  logic pop_valid;
  logic pop_ready;
  logic push_ready;
  logic ck_rise;
  logic ck_edge;
  lpddr_pkg::cmd_t cmd;
  logic [4:0] bl;
  logic [31:0] rd_data;
  logic [12:0] partial_array_self_refresh_mask;

  function automatic lpddr_pkg::cmd_t decode(input logic cke, input logic cs_n,
                                             input logic ras_n, input logic cas_n,
                                             input logic we_n);
    lpddr_pkg::cmd_t c;
    c = lpddr_pkg::C_NOP;
    if (!cs_n) begin
      case ({ras_n, cas_n, we_n})
        3'b111: c = lpddr_pkg::C_NOP;
        3'b011: c = lpddr_pkg::C_ACT;
        3'b101: c = lpddr_pkg::C_RD;
        3'b100: c = lpddr_pkg::C_WR;
        3'b110: c = cke ? lpddr_pkg::C_BST : lpddr_pkg::C_DPD;
        3'b010: c = lpddr_pkg::C_PRE;
        3'b001: c = cke ? lpddr_pkg::C_REF : lpddr_pkg::C_SREF;
        3'b000: c = lpddr_pkg::C_MRS;
        default: c = lpddr_pkg::C_BAD;
      endcase
      if (!cke && c != lpddr_pkg::C_DPD && c != lpddr_pkg::C_SREF &&
          c != lpddr_pkg::C_NOP) begin
        c = lpddr_pkg::C_BAD;
      end
    end
    return c;
  endfunction : decode

  function automatic logic [7:0] burst_col(input logic [7:0] start, input logic [3:0] k,
                                           input logic [4:0] len, input logic il);
    logic [7:0] m;
    logic [7:0] off;
    m = {3'h0, len - 5'h01};
    off = {3'h0, k, 1'b0};
    if (il) begin
      burst_col = start ^ off;
    end else begin
      burst_col = (start & ~m) | ((start + off) & m);
    end
  endfunction : burst_col

  function automatic logic [7:0] arr_idx(input logic [1:0] b, input logic [12:0] r,
                                         input logic [7:0] c);
    return {b, r[1:0], c[4:1]};
  endfunction : arr_idx

  function automatic logic all_idle(input lpddr_pkg::bank_t [3:0] b);
    return (b[0] == lpddr_pkg::B_IDLE) && (b[1] == lpddr_pkg::B_IDLE) &&
           (b[2] == lpddr_pkg::B_IDLE) && (b[3] == lpddr_pkg::B_IDLE);
  endfunction : all_idle

  assign raw = '{ck: ck_in, ck_n: ck_n_in, cke: cke_in, cs_n: cs_n_in, ras_n: ras_n_in,
                 cas_n: cas_n_in, we_n: we_n_in, ba: ba_in, addr: addr_in, dm: dm_in,
                 dqs: dqs_in, dq: dq_in, temp_hot: temp_hot_in};

  assign ck_rise = st_ff.s2.ck && !st_ff.s2.ck_n && !st_ff.ck_prev;
  assign ck_edge = st_ff.s2.ck != st_ff.ck_prev;
  assign cmd = decode(st_ff.s2.cke, st_ff.s2.cs_n, st_ff.s2.ras_n, st_ff.s2.cas_n,
                      st_ff.s2.we_n);
  assign bl = 5'h01 << st_ff.mode[lpddr_pkg::MODE_BL_LSB +: 3];
  assign rd_data = mem[arr_idx(st_ff.rd_bank, st_ff.row[st_ff.rd_bank],
                       burst_col(st_ff.rd_start, st_ff.rd_beat[4:1], bl,
                                 st_ff.mode[lpddr_pkg::MODE_IL_BIT]))];
  assign partial_array_self_refresh_mask = 13'h1fff >> st_ff.ext[lpddr_pkg::EXT_PARTIAL_ARRAY_SELF_REFRESH_LSB +: 2];
  assign pop_ready = !st_ff.rd_act && !st_ff.clr_act;

  lpddr_fifo #(.WIDTH($bits(lpddr_pkg::wr_item_t)), .DEPTH(lpddr_pkg::FIFO_DEPTH)) u_fifo (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .in_data_in(st_ff.wr_item),
    .in_valid_in(st_ff.wr_pend),
    .in_ready_out(push_ready),
    .out_data_out(pop_item),
    .out_valid_out(pop_valid),
    .out_ready_in(pop_ready)
  );

  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = raw;
    nxt_st.s2 = st_ff.s1;
    nxt_st.ck_prev = st_ff.s2.ck;
    nxt_st.dqs_prev = st_ff.s2.dqs;
    nxt_st.err = 1'b0;
    if (st_ff.clr_act) begin
      nxt_st.clr_idx = st_ff.clr_idx + 8'h01;
      nxt_st.clr_act = (st_ff.clr_idx != 8'hff);
    end
    // Read data out on both link clock edges, strobe edge aligned
    if (st_ff.rd_act && ck_edge && !(st_ff.rd_wait && !ck_rise)) begin
      nxt_st.rd_wait = 1'b0;
      if (st_ff.rd_beat == bl) begin
        nxt_st.rd_act = 1'b0;
        nxt_st.dq_oe_n = 1'b1;
        nxt_st.dqs_oe_n = 2'h3;
        nxt_st.bank[st_ff.rd_bank] = st_ff.rd_ap ? lpddr_pkg::B_IDLE
                                                 : lpddr_pkg::B_ACT;
      end else begin
        nxt_st.dq_oe_n = 1'b0;
        nxt_st.dqs_oe_n = 2'h0;
        nxt_st.dqs_o = {2{ck_rise}};
        if (!st_ff.rd_beat[0]) begin
          nxt_st.rd_word = rd_data;
          nxt_st.dq_o = rd_data[15:0];
        end else begin
          nxt_st.dq_o = st_ff.rd_word[31:16];
        end
        nxt_st.rd_beat = st_ff.rd_beat + 5'h01;
      end
    end
    // Write capture on every edge of each lane strobe
    if (st_ff.wr_pend && push_ready) begin
      nxt_st.wr_pend = 1'b0;
    end
    nxt_st.wr_seen = (st_ff.wr_seen == 2'h3) ? 2'h0 : st_ff.wr_seen;
    for (int i = 0; i < lpddr_pkg::LANES; i++) begin
      if (st_ff.wr_act && (st_ff.s2.dqs[i] != st_ff.dqs_prev[i])) begin
        nxt_st.wr_seen[i] = 1'b1;
        nxt_st.wr_cap[i*8 +: 8] = st_ff.s2.dq[i*8 +: 8];
        nxt_st.wr_mcap[i] = st_ff.s2.dm[i];
      end
    end
    if (st_ff.wr_act && st_ff.wr_seen == 2'h3) begin
      if (!st_ff.wr_beat[0]) begin
        nxt_st.wr_lo = st_ff.wr_cap;
        nxt_st.wr_mlo = st_ff.wr_mcap;
      end else begin
        nxt_st.err = st_ff.wr_pend && !push_ready;
        nxt_st.wr_pend = 1'b1;
        nxt_st.wr_item.idx = arr_idx(st_ff.wr_bank, st_ff.row[st_ff.wr_bank],
                                     burst_col(st_ff.wr_start, st_ff.wr_beat[4:1], bl,
                                               st_ff.mode[lpddr_pkg::MODE_IL_BIT]));
        nxt_st.wr_item.mask = {st_ff.wr_mcap, st_ff.wr_mlo};
        nxt_st.wr_item.data = {st_ff.wr_cap, st_ff.wr_lo};
      end
      nxt_st.wr_beat = st_ff.wr_beat + 5'h01;
      if (st_ff.wr_beat + 5'h01 == bl) begin
        nxt_st.wr_act = 1'b0;
        nxt_st.bank[st_ff.wr_bank] = st_ff.wr_ap ? lpddr_pkg::B_IDLE
                                                 : lpddr_pkg::B_ACT;
      end
    end
    // Self refresh ticks from the temperature-selected divider
    if (st_ff.pwr == lpddr_pkg::PWR_SELF) begin
      nxt_st.ref_cnt = st_ff.ref_cnt + 8'h01;
      if (st_ff.ref_cnt >= 8'(st_ff.s2.temp_hot ? lpddr_pkg::SR_HOT_CYC - 1
                                                : lpddr_pkg::SR_COOL_CYC - 1)) begin
        nxt_st.ref_cnt = 8'h00;
        nxt_st.ref_row = (st_ff.ref_row + 13'h0001) & partial_array_self_refresh_mask;
      end
      if (st_ff.s2.cke) begin
        nxt_st.pwr = lpddr_pkg::PWR_NORM;
      end
    end else if (st_ff.pwr == lpddr_pkg::PWR_DPD) begin
      if (st_ff.s2.cke && !st_ff.clr_act) begin
        nxt_st.pwr = lpddr_pkg::PWR_NORM;
      end
    end else if (ck_rise) begin
      nxt_st.last_cmd = cmd;
      case (cmd)
        lpddr_pkg::C_ACT: begin
          if (st_ff.bank[st_ff.s2.ba] != lpddr_pkg::B_IDLE) begin
            nxt_st.err = 1'b1;
          end else begin
            nxt_st.bank[st_ff.s2.ba] = lpddr_pkg::B_ACT;
            nxt_st.row[st_ff.s2.ba] = st_ff.s2.addr;
          end
        end
        lpddr_pkg::C_RD, lpddr_pkg::C_WR: begin
          if (st_ff.bank[st_ff.s2.ba] == lpddr_pkg::B_IDLE) begin
            nxt_st.err = 1'b1;
          end else begin
            if (st_ff.rd_act) begin
              nxt_st.bank[st_ff.rd_bank] = lpddr_pkg::B_ACT;
              nxt_st.rd_act = 1'b0;
              nxt_st.dq_oe_n = 1'b1;
              nxt_st.dqs_oe_n = 2'h3;
            end
            nxt_st.bank[st_ff.s2.ba] = lpddr_pkg::B_BURST;
            if (cmd == lpddr_pkg::C_RD) begin
              nxt_st.rd_act = 1'b1;
              nxt_st.rd_wait = 1'b1;
              nxt_st.rd_ap = st_ff.s2.addr[lpddr_pkg::AP_BIT];
              nxt_st.rd_bank = st_ff.s2.ba;
              nxt_st.rd_start = st_ff.s2.addr[7:0];
              nxt_st.rd_beat = 5'h00;
            end else begin
              nxt_st.wr_act = 1'b1;
              nxt_st.wr_ap = st_ff.s2.addr[lpddr_pkg::AP_BIT];
              nxt_st.wr_bank = st_ff.s2.ba;
              nxt_st.wr_start = st_ff.s2.addr[7:0];
              nxt_st.wr_beat = 5'h00;
              nxt_st.wr_seen = 2'h0;
            end
          end
        end
        lpddr_pkg::C_BST: begin
          if (st_ff.rd_act && !st_ff.rd_ap) begin
            nxt_st.rd_act = 1'b0;
            nxt_st.dq_oe_n = 1'b1;
            nxt_st.dqs_oe_n = 2'h3;
            nxt_st.bank[st_ff.rd_bank] = lpddr_pkg::B_ACT;
          end else begin
            nxt_st.err = 1'b1;
          end
        end
        lpddr_pkg::C_PRE: begin
          for (int b = 0; b < 4; b++) begin
            if (st_ff.s2.addr[lpddr_pkg::AP_BIT] || st_ff.s2.ba == 2'(b)) begin
              nxt_st.bank[b] = lpddr_pkg::B_IDLE;
            end
          end
          if (st_ff.s2.addr[lpddr_pkg::AP_BIT] || st_ff.s2.ba == st_ff.rd_bank) begin
            nxt_st.rd_act = 1'b0;
            nxt_st.dq_oe_n = 1'b1;
            nxt_st.dqs_oe_n = 2'h3;
          end
          if (st_ff.s2.addr[lpddr_pkg::AP_BIT] || st_ff.s2.ba == st_ff.wr_bank) begin
            nxt_st.wr_act = 1'b0;
          end
        end
        lpddr_pkg::C_REF: begin
          nxt_st.err = nxt_st.err || !all_idle(st_ff.bank);
          nxt_st.ref_row = st_ff.ref_row + 13'h0001;
        end
        lpddr_pkg::C_SREF: begin
          nxt_st.err = nxt_st.err || !all_idle(st_ff.bank);
          nxt_st.pwr = lpddr_pkg::PWR_SELF;
          nxt_st.ref_cnt = 8'h00;
        end
        lpddr_pkg::C_DPD: begin
          nxt_st.pwr = lpddr_pkg::PWR_DPD;
          nxt_st.bank = {4{lpddr_pkg::B_IDLE}};
          nxt_st.rd_act = 1'b0;
          nxt_st.wr_act = 1'b0;
          nxt_st.dq_oe_n = 1'b1;
          nxt_st.dqs_oe_n = 2'h3;
          nxt_st.clr_act = 1'b1;
          nxt_st.clr_idx = 8'h00;
        end
        lpddr_pkg::C_MRS: begin
          if (!all_idle(st_ff.bank) || st_ff.s2.ba == 2'h3) begin
            nxt_st.err = 1'b1;
          end else if (st_ff.s2.ba == lpddr_pkg::BA_MODE) begin
            nxt_st.mode = st_ff.s2.addr;
          end else if (st_ff.s2.ba == lpddr_pkg::BA_EXT) begin
            nxt_st.ext = st_ff.s2.addr;
          end
        end
        lpddr_pkg::C_BAD: nxt_st.err = 1'b1;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_ff <= '0;
      st_ff.mode <= lpddr_pkg::MODE_RST;
      st_ff.ext <= lpddr_pkg::EXT_RST;
      st_ff.dq_oe_n <= 1'b1;
      st_ff.dqs_oe_n <= 2'h3;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (st_ff.clr_act) begin
      mem[st_ff.clr_idx] <= 32'h0000_0000;
    end else if (pop_valid && pop_ready) begin
      for (int j = 0; j < 4; j++) begin
        if (!pop_item.mask[j]) begin
          mem[pop_item.idx][j*8 +: 8] <= pop_item.data[j*8 +: 8];
        end
      end
    end
  end

  assign dq_out = st_ff.dq_o;
  assign dq_oe_n_out = st_ff.dq_oe_n;
  assign dqs_out = st_ff.dqs_o;
  assign dqs_oe_n_out = st_ff.dqs_oe_n;
  assign power_state_out = st_ff.pwr;
  assign refresh_row_out = st_ff.ref_row;
  assign protocol_error_out = st_ff.err;
  assign last_cmd_out = st_ff.last_cmd;

  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  a_cmd_on_rise: assert property (!$past(ck_rise) |-> $stable(st_ff.last_cmd))
    else $error("command taken off a rising edge");
  a_read_drive: assert property ($fell(dq_oe_n_out) |-> $past(st_ff.rd_act))
    else $error("data driven outside a read burst");
  a_strobe_edge: assert property ($changed(dqs_out) |-> $past(ck_edge))
    else $error("strobe moved without a clock edge");
  a_dpd_entry: assert property (ck_rise && cmd == lpddr_pkg::C_DPD &&
      st_ff.pwr == lpddr_pkg::PWR_NORM |=> power_state_out == lpddr_pkg::PWR_DPD)
    else $error("deep power-down not entered");
  a_sref_entry: assert property (ck_rise && cmd == lpddr_pkg::C_SREF &&
      st_ff.pwr == lpddr_pkg::PWR_NORM |=> power_state_out == lpddr_pkg::PWR_SELF)
    else $error("self refresh not entered");
  a_ref_count: assert property (ck_rise && cmd == lpddr_pkg::C_REF &&
      st_ff.pwr == lpddr_pkg::PWR_NORM |=> refresh_row_out == $past(refresh_row_out) + 13'h0001)
    else $error("refresh row did not advance");
  a_sr_ignore: assert property (st_ff.pwr == lpddr_pkg::PWR_SELF |=> $stable(st_ff.bank))
    else $error("bank state changed in self refresh");
  a_pre_all: assert property (ck_rise && cmd == lpddr_pkg::C_PRE &&
      st_ff.pwr == lpddr_pkg::PWR_NORM && st_ff.s2.addr[10] |=> all_idle(st_ff.bank))
    else $error("precharge all left a bank open");
  a_bad_flag: assert property (ck_rise && cmd == lpddr_pkg::C_BAD &&
      st_ff.pwr == lpddr_pkg::PWR_NORM |=> protocol_error_out)
    else $error("reserved command not flagged");
  a_mode_ext: assert property (ck_rise && cmd == lpddr_pkg::C_MRS &&
      st_ff.pwr == lpddr_pkg::PWR_NORM && all_idle(st_ff.bank) &&
      st_ff.s2.ba == 2'h2 |=> st_ff.ext == $past(st_ff.s2.addr))
    else $error("extended mode register not loaded");

endmodule : lpddr_command_burst_interface
`default_nettype wire

// file: core/lpddr_fifo.sv
// Synchronous FIFO with valid and ready on both sides
// Assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ps
`default_nettype none
module lpddr_fifo #(
  parameter int WIDTH = 44,
  parameter int DEPTH = 32
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  output logic [WIDTH-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  lpddr_pkg::fifo_state_t st_ff;
  lpddr_pkg::fifo_state_t nxt_st;
  logic [5:0] used;
  logic push;
  logic pop;

  assign used = st_ff.wp - st_ff.rp;
  assign in_ready_out = (used != 6'(DEPTH));
  assign out_valid_out = (used != 6'h00);
  assign out_data_out = mem[st_ff.rp[AW-1:0]];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.wp = st_ff.wp + 6'h01;
    end
    if (pop) begin
      nxt_st.rp = st_ff.rp + 6'h01;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem[st_ff.wp[AW-1:0]] <= in_data_in;
    end
  end

endmodule : lpddr_fifo
`default_nettype wire

// file: core/lpddr_pkg.sv
// Shared types and constants of the LPDDR command and burst block
// Assumes a single 10 MHz system clock and pins sampled into it
package lpddr_pkg;

  localparam int CLK_NS = 100;
  localparam int SR_HOT_NS = 7800;
  localparam int SR_COOL_NS = 15600;
  localparam int SR_HOT_CYC = SR_HOT_NS / CLK_NS;
  localparam int SR_COOL_CYC = SR_COOL_NS / CLK_NS;

  localparam int LANES = 2;
  localparam int FIFO_DEPTH = 32;
  localparam logic [12:0] MODE_RST = 13'h0002;
  localparam logic [12:0] EXT_RST = 13'h0000;
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_IL_BIT = 3;
  localparam int EXT_PARTIAL_ARRAY_SELF_REFRESH_LSB = 0;
  localparam int AP_BIT = 10;
  localparam logic [1:0] BA_MODE = 2'h0;
  localparam logic [1:0] BA_STAT = 2'h1;
  localparam logic [1:0] BA_EXT = 2'h2;

  typedef enum logic [3:0] {
    C_NOP = 4'h0, C_ACT = 4'h1, C_RD = 4'h2, C_WR = 4'h3, C_BST = 4'h4,
    C_PRE = 4'h5, C_REF = 4'h6, C_MRS = 4'h7, C_SREF = 4'h8, C_DPD = 4'h9,
    C_BAD = 4'ha
  } cmd_t;

  typedef enum logic [1:0] {B_IDLE = 2'h0, B_ACT = 2'h1, B_BURST = 2'h2} bank_t;

  typedef enum logic [1:0] {PWR_NORM = 2'h0, PWR_SELF = 2'h1, PWR_DPD = 2'h2} pwr_t;

  typedef struct packed {
    logic ck;
    logic ck_n;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] ba;
    logic [12:0] addr;
    logic [1:0] dm;
    logic [1:0] dqs;
    logic [15:0] dq;
    logic temp_hot;
  } pins_t;

  typedef struct packed {
    logic [7:0] idx;
    logic [3:0] mask;
    logic [31:0] data;
  } wr_item_t;

  typedef struct packed {
    pins_t s1;
    pins_t s2;
    logic ck_prev;
    logic [1:0] dqs_prev;
    bank_t [3:0] bank;
    logic [3:0][12:0] row;
    logic [12:0] mode;
    logic [12:0] ext;
    pwr_t pwr;
    logic rd_act;
    logic rd_wait;
    logic rd_ap;
    logic [1:0] rd_bank;
    logic [7:0] rd_start;
    logic [4:0] rd_beat;
    logic [31:0] rd_word;
    logic [15:0] dq_o;
    logic dq_oe_n;
    logic [1:0] dqs_o;
    logic [1:0] dqs_oe_n;
    logic wr_act;
    logic wr_ap;
    logic [1:0] wr_bank;
    logic [7:0] wr_start;
    logic [4:0] wr_beat;
    logic [1:0] wr_seen;
    logic [15:0] wr_cap;
    logic [1:0] wr_mcap;
    logic [15:0] wr_lo;
    logic [1:0] wr_mlo;
    logic wr_pend;
    wr_item_t wr_item;
    logic [12:0] ref_row;
    logic [7:0] ref_cnt;
    logic clr_act;
    logic [7:0] clr_idx;
    logic err;
    cmd_t last_cmd;
  } state_t;

  typedef struct packed {
    logic [5:0] wp;
    logic [5:0] rp;
  } fifo_state_t;

endpackage : lpddr_pkg

// file: sim/lpddr_command_burst_interface_tb.sv
// Testbench: model drives pins, queues hold expected results
// Assumes 10 MHz system clock and the controller model
`timescale 1ns/1ps
`default_nettype none
module lpddr_command_burst_interface_tb;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic ck, dq_oe_n, oe_d, perr;
  lpddr_pkg::pins_t p;
  logic [1:0] dqs_o, dqs_oe_n, dqs_d, pwr;
  logic [15:0] dq_o;
  logic [12:0] rrow, r0;
  logic [3:0] lcmd, lcmd_d;
  logic [4:0] e;
  logic [17:0] b;
  logic [7:0][15:0] w;
  logic [4:0] exp_q[$];
  logic [17:0] dat_q[$];
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  always #50 clk_sys_in = ~clk_sys_in;
  lpddr_ctrl_model u_ctrl (.clk_sys_in(clk_sys_in), .ck_out(ck), .pins_out(p));
  lpddr_command_burst_interface u_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .ck_in(ck), .ck_n_in(~ck), .cke_in(p.cke), .cs_n_in(p.cs_n), .ras_n_in(p.ras_n),
    .cas_n_in(p.cas_n), .we_n_in(p.we_n), .ba_in(p.ba), .addr_in(p.addr), .dm_in(p.dm),
    .dqs_in(p.dqs), .dqs_out(dqs_o), .dqs_oe_n_out(dqs_oe_n), .dq_in(p.dq), .dq_out(dq_o),
    .dq_oe_n_out(dq_oe_n), .temp_hot_in(p.temp_hot), .power_state_out(pwr),
    .refresh_row_out(rrow), .protocol_error_out(perr), .last_cmd_out(lcmd));
  task automatic chk(input logic [17:0] got, input logic [17:0] ex);
    n_checks++;
    if (got !== ex) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, ex);
    end
  endtask : chk
  task automatic finish_test();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test
  // Note expected {error, code}, then send the command
  task automatic issue(input logic cke, input logic [3:0] c, input logic [1:0] ba,
    input logic [12:0] a, input logic [4:0] ex);
    exp_q.push_back(ex);
    u_ctrl.cmd(cke, c, ba, a);
  endtask : issue
  // Note n beats of w, strobe high on even beats, then read
  task automatic rd(input logic [1:0] ba, input logic [12:0] a, input int n);
    for (int i = 0; i < n; i++) begin
      dat_q.push_back({i[0] ? 2'b00 : 2'b11, w[i]});
    end
    issue(1'b1, 4'b0101, ba, a, 5'h02);
    repeat (n / 2 + 1) @(negedge ck);
  endtask : rd
  task automatic pwr_is(input logic [1:0] v);
    repeat (20) @(negedge clk_sys_in);
    chk({16'h0, pwr}, {16'h0, v});
  endtask : pwr_is
  // Watcher: oldest note against each new command and read beat
  always @(posedge clk_sys_in) begin
    cyc++;
    lcmd_d <= lcmd;
    dqs_d <= dqs_o;
    oe_d <= dq_oe_n;
    if (rst_n_in && lcmd !== lcmd_d && lcmd !== 4'h0) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 5'h1f;
      chk({14'h0, lcmd}, {14'h0, e[3:0]});
      chk({17'h0, perr}, {17'h0, e[4]});
    end
    if (dq_oe_n === 1'b0 && (oe_d !== 1'b0 || dqs_o !== dqs_d)) begin
      b = (dat_q.size() > 0) ? dat_q.pop_front() : 18'h3_ffff;
      chk({dqs_o, dq_o}, b);
      chk({16'h0, dqs_oe_n}, 18'h0);
    end
    if (cyc == 30000) begin
      miscompares++;
      finish_test();
    end
  end
  initial begin
    void'($urandom(28684));
    repeat (16) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    issue(1'b0, 4'b0110, 2'h0, 13'h0000, 5'h09);
    pwr_is(2'h2);
    repeat (300) @(posedge clk_sys_in);
    u_ctrl.cmd(1'b1, 4'b0111, 2'h0, 13'h0000);
    pwr_is(2'h0);
    issue(1'b0, 4'b0011, 2'h0, 13'h0005, 5'h1a);
    issue(1'b1, 4'b0011, 2'h0, 13'h0005, 5'h01);
    issue(1'b1, 4'b0101, 2'h1, 13'h0000, 5'h12);
    issue(1'b1, 4'b0100, 2'h0, 13'h0000, 5'h03);
    for (int i = 0; i < 4; i++) begin
      w[i] = 16'($urandom);
    end
    u_ctrl.wburst(w[3:0], 8'h08);
    repeat (30) @(posedge clk_sys_in);
    w[1][15:8] = 8'h00;
    // Plain read cut by burst stop after its first word
    for (int i = 0; i < 2; i++) begin
      dat_q.push_back({i[0] ? 2'b00 : 2'b11, w[i]});
    end
    issue(1'b1, 4'b0101, 2'h0, 13'h0000, 5'h02);
    issue(1'b1, 4'b0110, 2'h0, 13'h0000, 5'h04);
    rd(2'h0, 13'h0400, 4);
    issue(1'b1, 4'b0101, 2'h0, 13'h0000, 5'h12);
    issue(1'b1, 4'b0000, 2'h3, 13'h0001, 5'h17);
    issue(1'b1, 4'b0000, 2'h0, 13'h000b, 5'h07);
    issue(1'b1, 4'b0011, 2'h0, 13'h0005, 5'h01);
    // Eight beats interleaved from column two: words 1, 0, 3, 2
    w = {64'h0, w[1:0], w[3:2]};
    rd(2'h0, 13'h0402, 8);
    issue(1'b1, 4'b0000, 2'h0, 13'h0001, 5'h07);
    issue(1'b1, 4'b0000, 2'h2, 13'h0001, 5'h07);
    issue(1'b1, 4'b0011, 2'h1, 13'h0001, 5'h01);
    issue(1'b1, 4'b0011, 2'h2, 13'h0002, 5'h01);
    issue(1'b1, 4'b0010, 2'h1, 13'h0000, 5'h05);
    w = '0;
    rd(2'h2, 13'h0000, 2);
    issue(1'b1, 4'b0101, 2'h1, 13'h0000, 5'h12);
    issue(1'b1, 4'b0010, 2'h1, 13'h0400, 5'h05);
    issue(1'b1, 4'b0101, 2'h2, 13'h0000, 5'h12);
    issue(1'b1, 4'b0001, 2'h0, 13'h0000, 5'h06);
    issue(1'b0, 4'b0001, 2'h0, 13'h0000, 5'h08);
    r0 = rrow;
    pwr_is(2'h1);
    repeat (200) @(negedge clk_sys_in);
    chk({17'h0, rrow !== r0}, 18'h1);
    u_ctrl.cmd(1'b1, 4'b0111, 2'h0, 13'h0000);
    pwr_is(2'h0);
    chk(18'(exp_q.size() + dat_q.size()), 18'h0);
    finish_test();
  end
endmodule : lpddr_command_burst_interface_tb
`default_nettype wire

// file: sim/lpddr_ctrl_model.sv
// Controller model: free-running link clock, commands, write bursts
// Assumes pins change just after a clk_sys_in rising edge
`timescale 1ns/1ps
`default_nettype none
module lpddr_ctrl_model (
  input wire logic clk_sys_in,
  output logic ck_out,
  output var lpddr_pkg::pins_t pins_out
);
  initial begin
    ck_out = 1'b0;
    pins_out = '0;
    pins_out.cke = 1'b1;
    pins_out.cs_n = 1'b1;
    pins_out.temp_hot = 1'b1;
    #137;
    forever #400 ck_out = ~ck_out;
  end
  // One command at one clock rise, deselect after
  task automatic cmd(input logic cke, input logic [3:0] c, input logic [1:0] ba,
    input logic [12:0] a);
    @(negedge ck_out);
    @(posedge clk_sys_in);
    pins_out.cke <= cke;
    {pins_out.cs_n, pins_out.ras_n, pins_out.cas_n, pins_out.we_n} <= c;
    pins_out.ba <= ba;
    pins_out.addr <= a;
    @(negedge ck_out);
    @(posedge clk_sys_in);
    pins_out.cs_n <= 1'b1;
    pins_out.addr <= ~a;
  endtask : cmd
  // Data at clock edges, strobe toggled mid-eye
  task automatic wburst(input logic [3:0][15:0] d, input logic [3:0][1:0] m);
    for (int i = 0; i < 4; i++) begin
      @(ck_out);
      @(posedge clk_sys_in);
      pins_out.dq <= d[i];
      pins_out.dm <= m[i];
      repeat (2) @(posedge clk_sys_in);
      pins_out.dqs <= ~pins_out.dqs;
    end
    @(ck_out);
    @(posedge clk_sys_in);
    pins_out.dq <= ~pins_out.dq;
  endtask : wburst
endmodule : lpddr_ctrl_model
`default_nettype wire
